// ### include/parallel_port_params.svh
/*
  Constants for the processor-owned parallel port master: register
  offsets, field positions, reset values and bus-cycle timing.
  Assumes the clock runs at the instruction rate of 10 MHz.
*/
`ifndef PARALLEL_PORT_PARAMS_SVH
`define PARALLEL_PORT_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (register bus address)
// ----------------------------------------------------------------------
`define OFS_PORT_CONTROL        3'h0
`define OFS_PORT_CONFIG         3'h1
`define OFS_EP_ADDR_STATUS      3'h2
`define OFS_PARALLEL_DATA       3'h3
`define OFS_IRQ_CONTROL         3'h4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTL_ENABLE_BIT          0
`define CTL_OWNER_BIT           1
`define CFG_WS_LSB              0
`define CFG_WS_MSB              3
`define CFG_CLK1EN_BIT          4
`define CFG_CSEN_BIT            5
`define CFG_MODE_LSB            6
`define CFG_MODE_MSB            7
`define EPS_ADDR_LSB            0
`define EPS_ADDR_MSB            3
`define EPS_BUSY_BIT            4
`define EPS_WR_BIT              6
`define EPS_RD_BIT              7
`define IRQ_FLAG_BIT            0
`define IRQ_ENABLE_BIT          1
`define IRQ_PRIO_BIT            2

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define RST_BYTE                8'h00
`define RST_NIBBLE              4'h0
`define RST_MODE                2'h0
`define RST_WAIT                5'h00
`define ONE_WAIT                5'h01
`define ZERO_BIT                1'h0

`endif

// ### include/parallel_port_pkg.sv
/*
  Types for the processor-owned parallel port master.
  Assumes nothing beyond the constants header.
*/
package parallel_port_pkg;

  // bus cycle sequencer, gray coded along idle-phase1-phase2
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_PHASE1 = 2'b01,
    ST_PHASE2 = 2'b11
  } seq_state_type;

  // kind of bus cycle in flight
  typedef enum logic [1:0]
  {
    CYC_ADDR  = 2'h0,
    CYC_WRITE = 2'h1,
    CYC_READ  = 2'h2
  } cycle_kind_type;

  // strobe mode selection
  typedef enum logic [1:0]
  {
    MODE_ADDR_DATA = 2'h0,
    MODE_WR_RD     = 2'h1,
    MODE_ODD_EVEN  = 2'h2,
    MODE_ODD_EVEN2 = 2'h3
  } strobe_mode_type;

endpackage

// ### verilog/parallel_port_master.sv
/*
  Processor-owned streaming parallel port master: five registers on a
  plain register port, address/write/read strobe cycles with wait
  states on an 8-bit external bus, completion interrupt flag.
  Assumes clk is the instruction clock and all inputs are synchronous.
*/
`include "parallel_port_params.svh"

module parallel_port_master
  import parallel_port_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // external parallel bus
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe,
  output logic            strobe_one,
  output logic            strobe_two,
  output logic            bus_output_enable_n,
  output logic            bus_chip_select,
  // interrupt levels
  output logic            irq_high,
  output logic            irq_low
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic            port_enable_q;
  logic            port_owner_select_q;
  logic      [7:0] port_config_q;
  logic      [3:0] endpoint_addr_q;
  logic      [7:0] parallel_data_q;
  logic            port_irq_flag_q;
  logic            port_irq_enable_q;
  logic            port_irq_priority_q;
  seq_state_type   state_q;
  cycle_kind_type  kind_q;
  logic      [4:0] wait_q;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic            cpu_owned;
  logic            busy;
  logic            wr_ctl;
  logic            wr_cfg;
  logic            wr_eps;
  logic            wr_data;
  logic            rd_data;
  logic            wr_irq;
  logic            launch;
  logic            done;
  logic      [4:0] half_waits;
  strobe_mode_type mode;

  assign cpu_owned  = port_enable_q & ~port_owner_select_q;
  assign busy       = (state_q != ST_IDLE);
  assign wr_ctl     = clk_en & reg_wr & (reg_addr == `OFS_PORT_CONTROL);
  assign wr_cfg     = clk_en & reg_wr & (reg_addr == `OFS_PORT_CONFIG);
  assign wr_eps     = clk_en & reg_wr & (reg_addr == `OFS_EP_ADDR_STATUS);
  assign wr_data    = clk_en & reg_wr & (reg_addr == `OFS_PARALLEL_DATA);
  assign rd_data    = clk_en & reg_rd & (reg_addr == `OFS_PARALLEL_DATA);
  assign wr_irq     = clk_en & reg_wr & (reg_addr == `OFS_IRQ_CONTROL);
  // half waits: field value n gives 2n waits, n after each phase
  assign half_waits = {1'b0, port_config_q[`CFG_WS_MSB:`CFG_WS_LSB]};
  assign mode       = strobe_mode_type'(port_config_q[`CFG_MODE_MSB:`CFG_MODE_LSB]);
  // busy requests are dropped, software must poll first
  assign launch     = cpu_owned & ~busy & (wr_eps | wr_data | rd_data);
  // cycle ends after the second phase and its waits
  assign done       = clk_en & (state_q == ST_PHASE2) & (wait_q == `RST_WAIT);

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_enable_q       <= `ZERO_BIT;
      port_owner_select_q <= `ZERO_BIT;
      port_config_q       <= `RST_BYTE;
      port_irq_enable_q   <= `ZERO_BIT;
      port_irq_priority_q <= `ZERO_BIT;
    end
    else
    begin
      if (wr_ctl)
      begin
        port_enable_q       <= reg_wdata[`CTL_ENABLE_BIT];
        port_owner_select_q <= reg_wdata[`CTL_OWNER_BIT];
      end
      if (wr_cfg)
        port_config_q <= reg_wdata;
      if (wr_irq)
      begin
        port_irq_enable_q   <= reg_wdata[`IRQ_ENABLE_BIT];
        port_irq_priority_q <= reg_wdata[`IRQ_PRIO_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // endpoint address
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      endpoint_addr_q <= `RST_NIBBLE;
    // address field, not stored while a cycle runs
    else if (wr_eps && !busy)
      endpoint_addr_q <= reg_wdata[`EPS_ADDR_MSB:`EPS_ADDR_LSB];
  end

  // ----------------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      kind_q  <= CYC_ADDR;
      wait_q  <= `RST_WAIT;
    end
    else if (clk_en)
    begin
      case (state_q)
        ST_IDLE:
        begin
          // launch on address write, data write or data read
          if (launch)
          begin
            state_q <= ST_PHASE1;
            wait_q  <= half_waits;
            if (wr_eps)
              kind_q <= CYC_ADDR;
            else if (wr_data)
              kind_q <= CYC_WRITE;
            else
              kind_q <= CYC_READ;
          end
        end
        ST_PHASE1:
        begin
          if (wait_q == `RST_WAIT)
          begin
            state_q <= ST_PHASE2;
            wait_q  <= half_waits;
          end
          else
            wait_q <= wait_q - `ONE_WAIT;
        end
        ST_PHASE2:
        begin
          if (wait_q == `RST_WAIT)
            state_q <= ST_IDLE;
          else
            wait_q <= wait_q - `ONE_WAIT;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // data register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      parallel_data_q <= `RST_BYTE;
    else
    begin
      // written byte is what the write cycle drives
      if (launch && wr_data)
        parallel_data_q <= reg_wdata;
      // read result lands when the read cycle ends
      else if (done && kind_q == CYC_READ)
        parallel_data_q <= bus_data_in;
    end
  end

  // ----------------------------------------------------------------------
  // completion flag, set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      port_irq_flag_q <= `ZERO_BIT;
    // every completed cycle sets the flag
    else if (done)
      port_irq_flag_q <= 1'b1;
    else if (wr_irq && !reg_wdata[`IRQ_FLAG_BIT])
      port_irq_flag_q <= `ZERO_BIT;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_high <= `ZERO_BIT;
      irq_low  <= `ZERO_BIT;
    end
    else if (clk_en)
    begin
      // priority routing, one cycle behind the flag
      irq_high <= port_irq_flag_q & port_irq_enable_q & port_irq_priority_q;
      irq_low  <= port_irq_flag_q & port_irq_enable_q & ~port_irq_priority_q;
    end
  end

  // ----------------------------------------------------------------------
  // external bus pins
  // ----------------------------------------------------------------------
  logic       strobe_active;
  logic       sel_one;
  logic       is_write;
  logic [7:0] drive_byte;

  // strobe runs across phase one and its waits, falls in phase two
  assign strobe_active = clk_en ? (launch | (state_q == ST_PHASE1 && wait_q != `RST_WAIT))
                                : (state_q == ST_PHASE1);
  assign is_write      = launch ? (wr_eps | wr_data) : (kind_q != CYC_READ);
  assign drive_byte    = launch ? (wr_eps ? {4'h0, reg_wdata[3:0]} : reg_wdata)
                                : (kind_q == CYC_ADDR ? {4'h0, endpoint_addr_q}
                                                      : parallel_data_q);

  always_comb
  begin
    case (mode)
      MODE_ADDR_DATA:
        sel_one = launch ? wr_eps : (kind_q == CYC_ADDR);
      MODE_WR_RD:
        sel_one = is_write;
      MODE_ODD_EVEN, MODE_ODD_EVEN2:
        sel_one = launch && wr_eps ? reg_wdata[0] : endpoint_addr_q[0];
      default:
        sel_one = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      strobe_one          <= `ZERO_BIT;
      strobe_two          <= `ZERO_BIT;
      bus_data_out        <= `RST_BYTE;
      bus_data_oe         <= `ZERO_BIT;
      bus_output_enable_n <= 1'b1;
      bus_chip_select     <= `ZERO_BIT;
    end
    else if (clk_en)
    begin
      strobe_one <= strobe_active & sel_one &
                    port_config_q[`CFG_CLK1EN_BIT];
      strobe_two <= strobe_active & ~sel_one;
      // drive on writes, release on reads
      bus_data_oe         <= (launch | busy) & ~done & is_write;
      bus_data_out        <= drive_byte;
      bus_output_enable_n <= ~((launch | busy) & ~done & ~is_write);
      bus_chip_select     <= (launch | busy) & ~done & port_config_q[`CFG_CSEN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= `RST_BYTE;
    else if (clk_en && reg_rd)
    begin
      case (reg_addr)
        `OFS_PORT_CONTROL:
          reg_rdata <= {6'h00, port_owner_select_q, port_enable_q};
        `OFS_PORT_CONFIG:
          reg_rdata <= port_config_q;
        // status; read/write history only under usb, so zero
        `OFS_EP_ADDR_STATUS:
          reg_rdata <= {1'b0, 1'b0, 1'b0, busy, endpoint_addr_q};
        // returns byte from previous read cycle, or the last written data byte
        `OFS_PARALLEL_DATA:
          reg_rdata <= parallel_data_q;
        `OFS_IRQ_CONTROL:
          reg_rdata <= {5'h00, port_irq_priority_q, port_irq_enable_q,
                        port_irq_flag_q};
        default:
          reg_rdata <= `RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence seq_launch;
    launch && clk_en;
  endsequence

  AST_BUSY_ON_LAUNCH: assert property (@(posedge clk) disable iff (sys_rst)
    seq_launch |=> busy)
    else $error("busy did not rise after launch");
  AST_NOWAIT_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    (seq_launch and (half_waits == `RST_WAIT)) ##1 clk_en |=> (state_q == ST_PHASE2))
    else $error("wrong phase after zero wait launch");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (sys_rst)
    done |=> port_irq_flag_q)
    else $error("completion did not set flag");
  AST_IRQ_ROUTE: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && port_irq_flag_q && port_irq_enable_q && port_irq_priority_q) |=> irq_high)
    else $error("high priority irq not routed");
  AST_NO_LAUNCH_USB: assert property (@(posedge clk) disable iff (sys_rst)
    port_owner_select_q |-> !launch)
    else $error("cycle launched under usb ownership");
  AST_READ_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    (done && kind_q == CYC_READ) |=> (parallel_data_q == $past(bus_data_in)))
    else $error("read byte not captured");
  AST_BUSY_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    done |=> !busy)
    else $error("busy stayed after cycle end");
  AST_READ_NODRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    (busy && kind_q == CYC_READ) |=> !bus_data_oe)
    else $error("bus driven during read");

endmodule

// ### testbench/parallel_slave_model.sv
/*
  Slave model for the parallel port master bench.
  Assumes the bus pins come straight from the master and pull-ups on data.
*/
module parallel_slave_model
(
  // bus from master
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe,
  input  wire logic       bus_output_enable_n,
  // byte offered on reads
  input  wire logic [7:0] read_byte,
  // resolved data lines
  output logic      [7:0] bus_level
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // slave answers only while asked to; otherwise the master's byte or the pull-ups win, so
  // a stale byte can never pass for read data
  // bus turnaround
  always_comb
  begin
    if (bus_data_oe)
      bus_level = bus_data_out;
    else if (!bus_output_enable_n)
      bus_level = read_byte;
    else
      bus_level = 8'hFF;
  end
endmodule

// ### testbench/tb.sv
/*
  Self-checking bench for the parallel port master: register port tasks,
  expected bus events and read data in queues, one watcher process.
  Assumes the slave model resolves the data lines.
*/
`include "parallel_port_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, idle_seen = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, read_byte = 8'h00;
  logic [7:0]  reg_rdata, bus_data_in, bus_data_out;
  logic        bus_data_oe, strobe_one, strobe_two, bus_output_enable_n;
  logic        bus_chip_select, irq_high, irq_low;
  logic [3:0]  ws = 4'h0;
  logic [12:0] exp_bus[$];
  logic [12:0] snap;
  logic [8:0]  exp_rd[$];
  logic [8:0]  rd_item;
  int          num_errors = 0, checks = 0, wid = 0, busy_cnt = 0;

  always #50 clk = ~clk;

  parallel_port_master u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .strobe_one(strobe_one), .strobe_two(strobe_two),
    .bus_output_enable_n(bus_output_enable_n), .bus_chip_select(bus_chip_select),
    .irq_high(irq_high), .irq_low(irq_low));

  parallel_slave_model u_slave (.bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .bus_output_enable_n(bus_output_enable_n), .read_byte(read_byte),
    .bus_level(bus_data_in));

  // ----------------------------------------------------------------
  // watcher: read results and finished strobe cycles
  // ----------------------------------------------------------------
  always @(posedge clk) rd_d <= reg_rd;

  always @(negedge clk)
  begin
    if (rd_d)
    begin
      rd_item = exp_rd.pop_front();
      if (rd_item[8]) `CHK(reg_rdata, rd_item[7:0])
      else if (reg_rdata[`EPS_BUSY_BIT] === 1'b1) busy_cnt++;
      else idle_seen = 1'b1;
    end
    if (strobe_one | strobe_two)
    begin
      snap = {strobe_two, strobe_one, bus_chip_select, bus_data_oe, bus_output_enable_n,
              bus_data_oe ? bus_data_out : 8'h00};
      wid++;
    end
    else if (wid != 0)
    begin
      // an event nobody asked for fails against zero
      if (exp_bus.size() == 0) `CHK(snap, 13'h0000)
      else `CHK(snap, exp_bus.pop_front())
      `CHK(wid, ws + 1)
      wid = 0;
    end
  end

  // ----------------------------------------------------------------
  // register port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic chk, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_rd.push_back({chk, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // back-to-back status reads until idle; n < 0 skips the busy count
  task automatic poll(input int n);
    int k = 0;
    busy_cnt = 0;
    idle_seen = 1'b0;
    reg_addr <= `OFS_EP_ADDR_STATUS;
    reg_rd <= 1'b1;
    while (!idle_seen && k < 300)
    begin
      exp_rd.push_back(9'h000);
      @(posedge clk);
      k++;
    end
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
    if (n >= 0) `CHK(busy_cnt, n)
    `CHK(idle_seen, 1'b1)
  endtask

  function automatic logic [12:0] ev(input logic [1:0] k, input logic [1:0] m,
                                     input logic [3:0] a, input logic [7:0] d);
    logic s1, s2;
    s1 = (m[1] & a[0]) | (m == 2'd0 && k == 2'd0) | (m == 2'd1 && k == 2'd1);
    s2 = (m[1] & ~a[0]) | (m == 2'd0 && k != 2'd0) | (m == 2'd1 && k == 2'd2);
    return {s2, s1, m[0], k != 2'd2, k != 2'd2,
            k == 2'd0 ? {4'h0, a} : (k == 2'd1 ? d : 8'h00)};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one strobe mode end to end
  // ----------------------------------------------------------------
  task automatic run_mode(input logic [1:0] m);
    logic [3:0] a;
    logic [7:0] d, b, pb, cfg, irq;
    a = 4'($urandom);
    d = 8'($urandom);
    pb = 8'h00;
    ws = (m == 2'd0) ? 4'h0 : ((m == 2'd1) ? 4'hF : 4'($urandom));
    cfg = {m, m[0], 1'b1, ws};
    irq = {5'h00, m[0], m != 2'd3, 1'b0};
    wr(`OFS_PORT_CONTROL, 8'h00);
    wr(`OFS_PORT_CONFIG, cfg);
    wr(`OFS_IRQ_CONTROL, irq);
    wr(`OFS_EP_ADDR_STATUS, {4'h0, a});
    rd(`OFS_EP_ADDR_STATUS, 1'b1, {4'h0, a});
    rd(`OFS_PORT_CONFIG, 1'b1, cfg);
    wr(`OFS_PORT_CONTROL, 8'h01);
    if (m == 2'd0)
    begin
      exp_bus.push_back(ev(2'd0, m, a, 8'h00));
      wr(`OFS_EP_ADDR_STATUS, {4'h0, a});
      poll(2 + 2 * ws);
    end
    exp_bus.push_back(ev(2'd1, m, a, d));
    wr(`OFS_PARALLEL_DATA, d);
    poll(2 + 2 * ws);
    repeat (2) @(posedge clk);
    `CHK({irq_high, irq_low}, {irq[2] & irq[1], ~irq[2] & irq[1]})
    rd(`OFS_IRQ_CONTROL, 1'b1, irq | 8'h01);
    wr(`OFS_IRQ_CONTROL, irq);
    repeat (2) @(posedge clk);
    `CHK({irq_high, irq_low}, 2'b00)
    // second write lands while busy and launches nothing
    exp_bus.push_back(ev(2'd1, m, a, ~d));
    wr(`OFS_PARALLEL_DATA, ~d);
    wr(`OFS_PARALLEL_DATA, d);
    poll(-1);
    for (int j = 0; j < 3; j++)
    begin
      b = 8'($urandom);
      exp_bus.push_back(ev(2'd2, m, a, 8'h00));
      read_byte <= b;
      rd(`OFS_PARALLEL_DATA, j != 0, pb);
      @(posedge clk);
      poll(1 + 2 * ws);
      pb = b;
    end
    // usb ownership: data write must stay off the bus
    wr(`OFS_PORT_CONTROL, 8'h03);
    wr(`OFS_PARALLEL_DATA, d);
    repeat (40) @(posedge clk);
    `CHK(exp_bus.size(), 0)
    `CHK(wid, 0)
    $display("test mode %0d done", m);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h209a9ba2));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd(3'(i), 1'b1, 8'h00);
    wr(`OFS_PORT_CONTROL, 8'hFC);
    rd(`OFS_PORT_CONTROL, 1'b1, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 1'b1, 8'h00);
    // frozen clock enable: this write must not land
    clk_en <= 1'b0;
    wr(`OFS_PORT_CONTROL, 8'h01);
    clk_en <= 1'b1;
    rd(`OFS_PORT_CONTROL, 1'b1, 8'h00);
    $display("test reset_regs done");
    for (int m = 0; m < 4; m++)
      run_mode(2'(m));
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule
